// file: sfs_gap_timer.sv
/*
 * Shared constants of the flash command sequencer and its gap timer.
 * Assumes one clock, a synchronous active-low reset and a common clock enable.
 */
`timescale 1ns/100ps
`default_nettype none

package sfs_pkg;
    // -------------------------------------------------------------------
    // Memory command encodings {cs_n, ras_n, cas_n, we_n}
    // -------------------------------------------------------------------
    localparam logic [3:0] CMD_LOAD = 4'h0;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // -------------------------------------------------------------------
    // Operation codes placed on the low address byte at command load
    // -------------------------------------------------------------------
    localparam int CODE_W = 8;
    localparam logic [7:0] CODE_SETUP = 8'h40;
    localparam logic [7:0] CODE_STATUS = 8'h70;
    localparam int STATUS_W = 8;
    // -------------------------------------------------------------------
    // Gap timer width and sequencer states (Gray along the path)
    // -------------------------------------------------------------------
    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
    localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
    typedef enum logic [2:0] {
        SFS_IDLE = 3'h0,
        SFS_LOAD = 3'h1,
        SFS_ACT = 3'h3,
        SFS_COL = 3'h2
    } sfs_state_type;
endpackage : sfs_pkg

// -----------------------------------------------------------------------
// Down counter that spaces memory commands
// -----------------------------------------------------------------------
module sfs_gap_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [sfs_pkg::TMR_W-1:0] load_val,
    output logic zero
);
    import sfs_pkg::*;

    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] next_cnt;

    // Reload on request, else count down and stop at zero
    always_comb begin
        if (load) begin
            next_cnt = load_val;
        end else if (cnt != TMR_ZERO) begin
            next_cnt = cnt - TMR_ONE;
        end else begin
            next_cnt = cnt;
        end
    end

    // Register the count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= TMR_ZERO;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end

    assign zero = (cnt == TMR_ZERO);
endmodule // sfs_gap_timer

`default_nettype wire

// file: sfs_sequencer.sv
/*
 * Flash command sequencer: turns host writes into program triplets and host
 * reads into status-read triplets on an SDRAM-style command bus.
 * Assumes the flash samples commands on clk_sys and answers reads after the
 * configured CAS latency; host request signals are synchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module sfs_sequencer #(
    parameter int BANK_W = 2,
    parameter int ROW_W = 12,
    parameter int COL_W = 9,
    parameter int DATA_W = 16,
    parameter int CAS_LAT = 2,
    parameter int LOAD_GAP = 1,
    parameter int RCD_GAP = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [BANK_W+ROW_W+COL_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic req_done,
    output logic [sfs_pkg::STATUS_W-1:0] req_rdata,
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [BANK_W-1:0] mem_ba,
    output logic [ROW_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe_n,
    input wire logic [DATA_W-1:0] mem_dq_in
);
    import sfs_pkg::*;

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (ROW_W <= COL_W || ROW_W <= CODE_W) begin : g_bad_width
        $error("sfs_sequencer: ROW_W must exceed COL_W and the code width");
    end
    if (DATA_W < STATUS_W) begin : g_bad_data
        $error("sfs_sequencer: DATA_W must hold the status byte");
    end
    if (CAS_LAT < 1 || CAS_LAT > 3) begin : g_bad_cas
        $error("sfs_sequencer: CAS_LAT must be 1 to 3");
    end
    if (LOAD_GAP < 1 || RCD_GAP < 1 || LOAD_GAP > 16 || RCD_GAP > 16) begin : g_bad_gap
        $error("sfs_sequencer: command gaps must be 1 to 16 cycles");
    end

    localparam logic [TMR_W-1:0] LOAD_WAIT = TMR_W'(LOAD_GAP - 1);
    localparam logic [TMR_W-1:0] RCD_WAIT = TMR_W'(RCD_GAP - 1);
    localparam logic [TMR_W-1:0] CAS_WAIT = TMR_W'(CAS_LAT);

    // -------------------------------------------------------------------
    // Address helpers
    // -------------------------------------------------------------------
    // Command load address: upper row lines plus operation code
    function automatic logic [ROW_W-1:0] load_addr(input logic [ROW_W-1:0] row,
                                                   input logic [CODE_W-1:0] code);
        load_addr = {row[ROW_W-1:CODE_W], code};
    endfunction

    // Column address, zero extended to the bus
    function automatic logic [ROW_W-1:0] col_addr(input logic [COL_W-1:0] col);
        col_addr = {{(ROW_W-COL_W){1'b0}}, col};
    endfunction

    // -------------------------------------------------------------------
    // State and held request
    // -------------------------------------------------------------------
    sfs_state_type state, next_state;
    logic wr, next_wr;
    logic [BANK_W-1:0] bank, next_bank;
    logic [ROW_W-1:0] row, next_row;
    logic [COL_W-1:0] col, next_col;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [3:0] cmd, next_cmd;
    logic [BANK_W-1:0] next_ba;
    logic [ROW_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dq_out;
    logic next_dq_oe_n;
    logic next_done;
    logic [STATUS_W-1:0] next_rdata;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_zero;

    // Request accepted only while idle; host stalls otherwise
    assign req_ready = (state == SFS_IDLE);

    // Gap timer spacing the three commands
    sfs_gap_timer u_gap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .zero(tmr_zero)
    );

    // Next state, next pin values and capture
    always_comb begin
        next_state = state;
        next_wr = wr;
        next_bank = bank;
        next_row = row;
        next_col = col;
        next_wdata = wdata;
        next_cmd = CMD_NOP;
        next_ba = mem_ba;
        next_addr = mem_addr;
        next_dq_out = mem_dq_out;
        next_dq_oe_n = 1'b1;
        next_done = 1'b0;
        next_rdata = req_rdata;
        tmr_load = 1'b0;
        tmr_val = TMR_ZERO;
        case (state)
            SFS_IDLE: begin
                if (req_valid) begin
                    next_wr = req_write;
                    next_bank = req_addr[BANK_W+ROW_W+COL_W-1:ROW_W+COL_W];
                    next_row = req_addr[ROW_W+COL_W-1:COL_W];
                    next_col = req_addr[COL_W-1:0];
                    next_wdata = req_wdata;
                    next_cmd = CMD_LOAD;
                    next_ba = req_addr[BANK_W+ROW_W+COL_W-1:ROW_W+COL_W];
                    // Setup code for writes, status code for reads
                    next_addr = load_addr(req_addr[ROW_W+COL_W-1:COL_W],
                                          req_write ? CODE_SETUP : CODE_STATUS);
                    tmr_load = 1'b1;
                    tmr_val = LOAD_WAIT;
                    next_state = SFS_LOAD;
                end
            end
            SFS_LOAD: begin
                if (tmr_zero) begin
                    next_cmd = CMD_ACT;
                    next_ba = bank;
                    next_addr = row;
                    tmr_load = 1'b1;
                    tmr_val = RCD_WAIT;
                    next_state = SFS_ACT;
                end
            end
            SFS_ACT: begin
                if (tmr_zero) begin
                    next_ba = bank;
                    next_addr = col_addr(col);
                    tmr_load = 1'b1;
                    next_state = SFS_COL;
                    if (wr) begin
                        // Single word, data driven for this cycle only
                        next_cmd = CMD_WRITE;
                        next_dq_out = wdata;
                        next_dq_oe_n = 1'b0;
                        tmr_val = TMR_ZERO;
                    end else begin
                        next_cmd = CMD_READ;
                        tmr_val = CAS_WAIT;
                    end
                end
            end
            SFS_COL: begin
                if (tmr_zero) begin
                    if (!wr) begin
                        next_rdata = mem_dq_in[STATUS_W-1:0];
                    end
                    next_done = 1'b1;
                    next_state = SFS_IDLE;
                end
            end
            default: begin
                next_state = SFS_IDLE;
            end
        endcase
    end

    // Register state, request and pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= SFS_IDLE;
            wr <= 1'b0;
            bank <= '0;
            row <= '0;
            col <= '0;
            wdata <= '0;
            cmd <= CMD_NOP;
            mem_ba <= '0;
            mem_addr <= '0;
            mem_dq_out <= '0;
            mem_dq_oe_n <= 1'b1;
            req_done <= 1'b0;
            req_rdata <= '0;
        end else if (ce) begin
            state <= next_state;
            wr <= next_wr;
            bank <= next_bank;
            row <= next_row;
            col <= next_col;
            wdata <= next_wdata;
            cmd <= next_cmd;
            mem_ba <= next_ba;
            mem_addr <= next_addr;
            mem_dq_out <= next_dq_out;
            mem_dq_oe_n <= next_dq_oe_n;
            req_done <= next_done;
            req_rdata <= next_rdata;
        end
    end

    // Command pins straight from the command register
    assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    // Helpers: last command issued, and enabled edges counted since Read
    logic [3:0] last_cmd, next_last_cmd;
    logic [TMR_W-1:0] rd_edges, next_rd_edges;

    // Remember the previous command; count read latency in enabled edges
    always_comb begin
        next_last_cmd = last_cmd;
        next_rd_edges = rd_edges;
        if (ce && cmd != CMD_NOP) begin
            next_last_cmd = cmd;
        end
        if (ce && cmd == CMD_READ) begin
            next_rd_edges = TMR_ONE;
        end else if (ce && rd_edges == CAS_WAIT) begin
            next_rd_edges = TMR_ZERO;
        end else if (ce && rd_edges != TMR_ZERO) begin
            next_rd_edges = rd_edges + TMR_ONE;
        end
    end

    // Register the helpers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last_cmd <= CMD_NOP;
            rd_edges <= TMR_ZERO;
        end else begin
            last_cmd <= next_last_cmd;
            rd_edges <= next_rd_edges;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_load_first_cmd: assert property (ce && state == SFS_IDLE && req_valid |=>
        cmd == CMD_LOAD && state == SFS_LOAD)
        else $error("accepted request did not issue command load");
    a_setup_code: assert property (cmd == CMD_LOAD && wr |->
        mem_addr[CODE_W-1:0] == CODE_SETUP)
        else $error("program load lacks setup code");
    a_load_target: assert property (cmd == CMD_LOAD |->
        mem_ba == bank && mem_addr[ROW_W-1:CODE_W] == row[ROW_W-1:CODE_W])
        else $error("command load lacks target bank or address");
    a_act_row_bank: assert property (cmd != CMD_NOP && last_cmd == CMD_LOAD |->
        cmd == CMD_ACT && mem_addr == row && mem_ba == bank)
        else $error("command after load is not a matching active");
    a_write_data: assert property (cmd == CMD_WRITE |->
        !mem_dq_oe_n && mem_dq_out == wdata && mem_ba == bank && mem_addr == col_addr(col))
        else $error("write cycle lacks column, bank or data");
    a_no_burst_stop: assert property (cmd != CMD_BURST_STOP &&
        (cmd == CMD_WRITE || mem_dq_oe_n))
        else $error("burst stop issued or data driven outside write");
    a_status_code: assert property (cmd == CMD_LOAD && !wr |->
        mem_addr[CODE_W-1:0] == CODE_STATUS)
        else $error("status load lacks status code");
    a_read_column: assert property (cmd == CMD_READ |->
        !wr && mem_ba == bank && mem_addr == col_addr(col))
        else $error("read cycle lacks bank or column");
    a_status_capture: assert property (ce && rd_edges == CAS_WAIT |=>
        req_done && req_rdata == $past(mem_dq_in[STATUS_W-1:0]))
        else $error("status byte not captured after latency");
    a_host_stall: assert property ($rose(req_ready) && $past(rst_n) |-> req_done)
        else $error("host released before sequence end");

    c_program_done: cover property (cmd == CMD_WRITE ##[1:4] req_done);
    c_status_done: cover property (cmd == CMD_READ ##[1:8] req_done);
    c_back_to_back: cover property (req_done ##1 cmd == CMD_LOAD);
endmodule // sfs_sequencer

`default_nettype wire

// file: sfs_flash_model.sv
/*
 * Behavioural flash on the command bus: answers status reads after CAS_LAT.
 * Assumes the sequencer's command pins and the shared clock enable.
 */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Status answer model
// ---------------------------------------------------------------------
module sfs_flash_model #(
    parameter int DATA_W = 16,
    parameter int CAS_LAT = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [7:0] status,
    output logic [DATA_W-1:0] mem_dq_in
);
    import sfs_pkg::*;
    int cnt = 0;
    logic [DATA_W-1:0] filler = '0;
    // Count latency from the enabled edge that sees Read; filler moves each cycle
    always @(posedge clk_sys) begin
        filler <= {filler[DATA_W-2:0], ~filler[DATA_W-1]};
        if (!rst_n)
            cnt <= 0;
        else if (ce && {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} == CMD_READ)
            cnt <= CAS_LAT;
        else if (ce && cnt > 0)
            cnt <= cnt - 1;
    end
    // Status on the low byte only in the cycle before capture, else a moving pattern
    assign mem_dq_in = (cnt == 1) ? {~filler[DATA_W-1:8], status} : filler;
endmodule // sfs_flash_model

`default_nettype wire

// file: sfs_sequencer_test.sv
/*
 * Self-checking bench: random writes and status reads against a queue model.
 * Assumes sfs_flash_model on the far side and a free-running clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------------
module sfs_sequencer_test;
    import sfs_pkg::*;
    localparam int LG = 2;
    localparam int RG = 3;
    localparam int CL = 3;
    typedef struct {int edge_no; logic [3:0] cmd; logic [1:0] ba; logic [11:0] addr;
        logic [15:0] dq;} sfs_cmd_type;
    typedef struct {int edge_no; logic rd; logic [7:0] st;} sfs_done_type;
    logic clk_sys = 0, rst_n = 0, ce = 1, req_valid = 0, req_write = 0, ce_seen = 0;
    logic [22:0] req_addr = '0;
    logic [15:0] req_wdata = '0, mem_dq_out, mem_dq_in;
    logic [7:0] req_rdata, status = '0;
    logic req_ready, req_done, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe_n;
    logic [1:0] mem_ba;
    logic [11:0] mem_addr;
    logic [3:0] cmd;
    int miscompares = 0, n_compared = 0, seed = 32'heb7b, n_edge = 0, rand_ce = 0, i;
    logic [31:0] r;
    sfs_cmd_type exp_cmd[$], e;
    sfs_done_type done_q[$], d;

    sfs_sequencer #(.LOAD_GAP(LG), .RCD_GAP(RG), .CAS_LAT(CL)) sfs_sequencer_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .req_done(req_done), .req_rdata(req_rdata),
        .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in));
    sfs_flash_model #(.DATA_W(16), .CAS_LAT(CL)) sfs_flash_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .mem_cs_n(mem_cs_n),
        .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
        .status(status), .mem_dq_in(mem_dq_in));

    // Clock, random clock enable and watchdog
    initial forever #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (rand_ce != 0) ce <= ($random(seed) & 3) != 0;
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic step();
        @(negedge clk_sys);
        #1;
    endtask

    // Present one request, hold it until taken, then queue what must follow
    task automatic issue(input logic w, input logic [22:0] a, input logic [15:0] dw);
        int k;
        logic [7:0] st;
        step();
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = dw;
        while (!(ce && req_ready === 1'b1)) step();
        st = $random(seed);
        status = st;
        k = n_edge + 1;
        exp_cmd.push_back('{k, CMD_LOAD, a[22:21], {a[20:17], w ? CODE_SETUP : CODE_STATUS}, 0});
        exp_cmd.push_back('{k + LG, CMD_ACT, a[22:21], a[20:9], 0});
        exp_cmd.push_back('{k + LG + RG, w ? CMD_WRITE : CMD_READ, a[22:21], {3'h0, a[8:0]}, dw});
        done_q.push_back('{k + LG + RG + 1 + (w ? 0 : CL), !w, st});
    endtask

    // Pin monitor: counts enabled edges and compares against the queues
    always @(posedge clk_sys) ce_seen <= ce && rst_n;
    always @(negedge clk_sys) begin
        if (ce_seen)
            n_edge++;
        cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
        if (rst_n) begin
            check(mem_dq_oe_n, cmd != CMD_WRITE, "dq enable");
            check(cmd == CMD_BURST_STOP, 0, "burst stop");
            if (done_q.size() > 0 && n_edge < done_q[0].edge_no)
                check(req_ready, 0, "host stall");
            if (ce_seen && cmd != CMD_NOP) begin
                e = exp_cmd.pop_front();
                check(n_edge, e.edge_no, "cmd time");
                check(cmd, e.cmd, "cmd");
                check(mem_ba, e.ba, "bank");
                check(mem_addr, e.addr, "addr");
                if (cmd == CMD_WRITE)
                    check(mem_dq_out, e.dq, "wdata");
            end
            if (ce_seen && req_done === 1'b1) begin
                d = done_q.pop_front();
                check(n_edge, d.edge_no, "done time");
                if (d.rd)
                    check(req_rdata, d.st, "status");
            end else if (done_q.size() > 0 && done_q[0].edge_no < n_edge) begin
                check(0, 1, "missing done");
                void'(done_q.pop_front());
            end
        end
    end

    task automatic drain();
        for (int t = 0; t < 200 && done_q.size() > 0; t++) step();
        req_valid = 0;
    endtask

    // Main sequence: edges of the address space, random mix, reset mid-sequence
    initial begin
        repeat (6) step();
        rst_n = 1;
        issue(1, '1, 16'hFFFF);
        issue(0, '0, 16'h0000);
        for (i = 0; i < 60; i++) begin
            if (i == 30)
                rand_ce = 1;
            r = $random(seed);
            issue(r[0], r[31:9], r[24:9] ^ r[15:0]);
        end
        drain();
        rand_ce = 0;
        ce = 1;
        issue(0, 23'h5ABCDE, 16'h0000);
        step();
        req_valid = 0;
        rst_n = 0;
        step();
        exp_cmd.delete();
        done_q.delete();
        check({req_ready, cmd, mem_dq_oe_n, req_done, req_rdata}, 15'h5E00, "reset values");
        rst_n = 1;
        issue(0, 23'h2C3A5F, 16'h0000);
        issue(1, 23'h13579B, 16'hBEEF);
        drain();
        check(exp_cmd.size() + done_q.size(), 0, "left over");
        give_verdict();
    end

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
endmodule // sfs_sequencer_test

`default_nettype wire
